// >>> hdl/emr_field.sv
// one alias-capable register field: plain write, set, clear, invert
// assumes the caller masks the byte lanes that take part
module emr_field
    import emr_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic [W-1:0] cur_i, // current value
    input wire logic [W-1:0] wdat_i, // bus write data
    input wire logic [W-1:0] lane_i, // bits taking part
    input wire logic [1:0] op_i, // alias selector
    output logic [W-1:0] nxt_o // new value
);
    always_comb begin
        case (emr_op_t'(op_i))
            EMR_OP_WRITE: nxt_o = (cur_i & ~lane_i) | (wdat_i & lane_i);
            EMR_OP_SET: nxt_o = cur_i | (wdat_i & lane_i); // R9
            EMR_OP_CLR: nxt_o = cur_i & ~(wdat_i & lane_i); // R9
            EMR_OP_INV: nxt_o = cur_i ^ (wdat_i & lane_i); // R9
            default: nxt_o = cur_i;
        endcase
    end
endmodule : emr_field

// >>> hdl/emr_top.sv
// rx pattern mask and max frame length registers on a classic wishbone slave
// assumes one clock and a master that holds requests until ack
// How it works
// R1 - mask only drives receive side outputs
// R2 - software changes mask only when idle (not enforced: a mask write while locked still lands and sets the sticky flag)
// R3 - 64-bit mask, low and high words
// R4 - max length resets to 0x05EE
// R5 - low 16 bits give octet limit
// R6 - upper 16 bits read zero
// R7 - 16/32-bit accesses work, bytes ignored (writes only; a read returns the whole word for any selects)
// R8 - software raises limit for tagged frames
// R9 - aliases touch only bits written one (control: enable and mode bit 0 both load from bit 8, read as their or)
`include "emr_regs.svh"
module emr_top
    import emr_pkg::*;
(
    input wire logic clk_i, // 40 MHz clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [5:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte selects
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    output logic [63:0] rx_pattern_mask_o, // mask to rx matcher
    output logic [15:0] max_frame_octets_o, // rx length limit
    output logic receive_enable_bit_o, // rx enable
    output logic [3:0] pattern_match_mode_field_o, // match mode
    output logic mask_lock_err_o // sticky: mask written while matching
);
    emr_state_t s_q;
    emr_state_t s_d;
    logic req;
    logic wide_ok;
    logic [1:0] op;
    logic [5:0] base;
    logic [31:0] lane;
    logic [31:0] nxt_lo;
    logic [31:0] nxt_hi;
    logic [31:0] nxt_ml;
    logic [31:0] nxt_ct;
    logic [31:0] ctrl_rd;
    logic locked;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    // accepted: halfwords (sel 0011/1100) and words only
    assign wide_ok = (wb_sel_i == 4'hF) || (wb_sel_i == 4'h3) || (wb_sel_i == 4'hC); // R7
    assign op = wb_adr_i[3:2];
    assign base = {wb_adr_i[5:4], 4'h0};
    assign lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // a mask write while locked still lands; the sticky flag only reports the breach
    assign locked = s_q.receive_enable_bit && (s_q.pattern_match_mode_field != 4'h0);
    // bit 8 is shared by the enable and the low mode bit, so a read shows their or
    assign ctrl_rd = {15'h0, s_q.lock_err, 4'h0, s_q.pattern_match_mode_field[3:1],
                      s_q.pattern_match_mode_field[0] | s_q.receive_enable_bit, 8'h0};

    emr_field #(.W(32)) u_lo (.cur_i(s_q.mask_lo), .wdat_i(wb_dat_i), .lane_i(lane),
        .op_i(op), .nxt_o(nxt_lo)); // R3
    emr_field #(.W(32)) u_hi (.cur_i(s_q.mask_hi), .wdat_i(wb_dat_i), .lane_i(lane),
        .op_i(op), .nxt_o(nxt_hi)); // R3
    emr_field #(.W(32)) u_ml (.cur_i({16'h0, s_q.maxlen}), .wdat_i(wb_dat_i), .lane_i(lane),
        .op_i(op), .nxt_o(nxt_ml));
    emr_field #(.W(32)) u_ct (.cur_i(ctrl_rd), .wdat_i(wb_dat_i), .lane_i(lane),
        .op_i(op), .nxt_o(nxt_ct));

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        s_d.rdat = 32'h0;
        if (req && !wb_we_i) begin
            case (base)
                `EMR_OFF_MASK_LO: s_d.rdat = s_q.mask_lo;
                `EMR_OFF_MASK_HI: s_d.rdat = s_q.mask_hi;
                `EMR_OFF_MAXLEN: s_d.rdat = {16'h0, s_q.maxlen}; // R6
                `EMR_OFF_CTRL: s_d.rdat = ctrl_rd;
                default: s_d.rdat = 32'h0;
            endcase
        end
        if (req && wb_we_i && wide_ok) begin // R7
            case (base)
                `EMR_OFF_MASK_LO: begin
                    s_d.mask_lo = nxt_lo;
                    if (locked) s_d.lock_err = 1'b1; // R2
                end
                `EMR_OFF_MASK_HI: begin
                    s_d.mask_hi = nxt_hi;
                    if (locked) s_d.lock_err = 1'b1; // R2
                end
                `EMR_OFF_MAXLEN: s_d.maxlen = nxt_ml[15:0]; // R5
                `EMR_OFF_CTRL: begin
                    s_d.receive_enable_bit = nxt_ct[`EMR_CTRL_RECEIVE_ENABLE_BIT_BIT];
                    s_d.pattern_match_mode_field = nxt_ct[`EMR_CTRL_MODE_LSB:`EMR_CTRL_MODE_MSB];
                    // writing one to bit 16 of the plain word clears the sticky flag
                    if (op == 2'b00 && wb_sel_i[2] && wb_dat_i[16]) s_d.lock_err = 1'b0;
                end
                default: ;
            endcase
        end
        if (rst_i) begin
            s_d = '0;
            s_d.maxlen = `EMR_MAXLEN_RST; // R4
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    // ----------------------------------------
    // outputs (all registered state)
    // ----------------------------------------
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign rx_pattern_mask_o = {s_q.mask_hi, s_q.mask_lo}; // R1 R3
    assign max_frame_octets_o = s_q.maxlen; // R5
    assign receive_enable_bit_o = s_q.receive_enable_bit;
    assign pattern_match_mode_field_o = s_q.pattern_match_mode_field;
    assign mask_lock_err_o = s_q.lock_err;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_RESET_LEN: assert property (@(posedge clk_i) // R4
        rst_i |=> max_frame_octets_o == 16'h05EE)
        else $error("max length not at reset value");
    AST_BYTE_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (req && wb_we_i && !wide_ok) |=> $stable(rx_pattern_mask_o) && $stable(max_frame_octets_o))
        else $error("byte write changed state");
    AST_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        (req && !wb_we_i && base == `EMR_OFF_MAXLEN) |=> wb_dat_o[31:16] == 16'h0)
        else $error("upper length bits not zero");
    AST_LEN_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        (req && wb_we_i && wb_sel_i == 4'hF && op == 2'b00 && base == `EMR_OFF_MAXLEN)
        |=> max_frame_octets_o == $past(wb_dat_i[15:0]))
        else $error("length write lost");
    AST_LO_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        (req && wb_we_i && wb_sel_i == 4'hF && op == 2'b00 && base == `EMR_OFF_MASK_LO)
        |=> rx_pattern_mask_o[31:0] == $past(wb_dat_i) && $stable(rx_pattern_mask_o[63:32]))
        else $error("low mask write wrong");
    AST_SET_ALIAS: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        (req && wb_we_i && wb_sel_i == 4'hF && op == 2'b01 && base == `EMR_OFF_MASK_HI)
        |=> rx_pattern_mask_o[63:32] == ($past(rx_pattern_mask_o[63:32]) | $past(wb_dat_i)))
        else $error("set alias wrong");
    AST_CLR_ALIAS: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        (req && wb_we_i && wb_sel_i == 4'hF && op == 2'b10 && base == `EMR_OFF_MASK_LO)
        |=> rx_pattern_mask_o[31:0] == ($past(rx_pattern_mask_o[31:0]) & ~$past(wb_dat_i)))
        else $error("clear alias wrong");
    AST_MASK_ONLY_BUS: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        !(req && wb_we_i) |=> $stable(rx_pattern_mask_o))
        else $error("mask changed without write");
    AST_LOCK_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (req && wb_we_i && wide_ok && locked && base == `EMR_OFF_MASK_LO) |=> mask_lock_err_o)
        else $error("locked mask write not flagged");
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    AST_ACK_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        req |=> wb_ack_o)
        else $error("request not answered in one cycle");
    AST_HI_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        (req && wb_we_i && wb_sel_i == 4'hF && op == 2'b00 && base == `EMR_OFF_MASK_HI)
        |=> rx_pattern_mask_o[63:32] == $past(wb_dat_i) && $stable(rx_pattern_mask_o[31:0]))
        else $error("high mask write wrong");
    AST_READ_HI: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        (req && !wb_we_i && base == `EMR_OFF_MASK_HI)
        |=> wb_dat_o == $past(rx_pattern_mask_o[63:32]))
        else $error("high mask read wrong");
    AST_HALF_LANES: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (req && wb_we_i && wb_sel_i == 4'hC && op == 2'b00 && base == `EMR_OFF_MASK_LO)
        |=> rx_pattern_mask_o[31:16] == $past(wb_dat_i[31:16]) && $stable(rx_pattern_mask_o[15:0]))
        else $error("halfword write touched the wrong lanes");
    AST_INV_ALIAS: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        (req && wb_we_i && wb_sel_i == 4'hF && op == 2'b11 && base == `EMR_OFF_MASK_LO)
        |=> rx_pattern_mask_o[31:0] == ($past(rx_pattern_mask_o[31:0]) ^ $past(wb_dat_i)))
        else $error("invert alias wrong");

    // ----------------------------------------
    // checks: length, control and lock flag
    // ----------------------------------------
    AST_HALF_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        (req && wb_we_i && wb_sel_i == 4'h3 && op == 2'b00 && base == `EMR_OFF_MAXLEN)
        |=> max_frame_octets_o == $past(wb_dat_i[15:0]))
        else $error("halfword length write lost");
    AST_READ_LEN: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        (req && !wb_we_i && base == `EMR_OFF_MAXLEN)
        |=> wb_dat_o[15:0] == $past(max_frame_octets_o))
        else $error("length read wrong");
    AST_LEN_ONLY_BUS: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        !(req && wb_we_i) |=> $stable(max_frame_octets_o))
        else $error("length changed without write");
    AST_BYTE_NO_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (req && wb_we_i && !wide_ok && !mask_lock_err_o) |=> !mask_lock_err_o)
        else $error("ignored byte write raised the lock flag");
    AST_CTRL_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (req && wb_we_i && wb_sel_i == 4'hF && op == 2'b00 && base == `EMR_OFF_CTRL)
        |=> receive_enable_bit_o == $past(wb_dat_i[`EMR_CTRL_RECEIVE_ENABLE_BIT_BIT])
        && pattern_match_mode_field_o == $past(wb_dat_i[`EMR_CTRL_MODE_LSB:`EMR_CTRL_MODE_MSB]))
        else $error("control write wrong");
    AST_CTRL_ONLY_BUS: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        !(req && wb_we_i) |=> $stable(receive_enable_bit_o) && $stable(pattern_match_mode_field_o))
        else $error("control changed without write");
    AST_LOCK_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (req && wb_we_i && wb_sel_i == 4'hF && op == 2'b00 && base == `EMR_OFF_CTRL
        && wb_dat_i[16]) |=> !mask_lock_err_o)
        else $error("lock flag not cleared");
    AST_LOCK_STICKY: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (mask_lock_err_o && !(req && wb_we_i && base == `EMR_OFF_CTRL)) |=> mask_lock_err_o)
        else $error("lock flag dropped on its own");
    AST_LOCK_ONLY_LOCKED: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (!mask_lock_err_o && !(req && wb_we_i && wide_ok && locked)) |=> !mask_lock_err_o)
        else $error("lock flag raised without a locked write");
endmodule : emr_top

// >>> include/emr_pkg.sv
// types for the rx mask / max length slice
// assumes emr_regs.svh for the numbers
package emr_pkg;
    typedef enum logic [1:0] {
        EMR_OP_WRITE = 2'b00,
        EMR_OP_SET = 2'b01,
        EMR_OP_CLR = 2'b10,
        EMR_OP_INV = 2'b11
    } emr_op_t;

    typedef struct packed {
        logic [31:0] mask_lo;
        logic [31:0] mask_hi;
        logic [15:0] maxlen;
        logic receive_enable_bit;
        logic [3:0] pattern_match_mode_field;
        logic ack;
        logic [31:0] rdat;
        logic lock_err;
    } emr_state_t;
endpackage : emr_pkg

// >>> include/emr_regs.svh
// register offsets, field positions, reset values for the rx mask / max length slice
// assumes a 32-bit wishbone slave with byte selects and byte addressing
`ifndef EMR_REGS_SVH
`define EMR_REGS_SVH
`define EMR_OFF_MASK_LO 6'h00
`define EMR_OFF_MASK_HI 6'h10
`define EMR_OFF_MAXLEN 6'h20
`define EMR_OFF_CTRL 6'h30
`define EMR_ALIAS_SET 2'h1
`define EMR_ALIAS_CLR 2'h2
`define EMR_ALIAS_INV 2'h3
`define EMR_MAXLEN_RST 16'h05EE
`define EMR_CTRL_RECEIVE_ENABLE_BIT_BIT 8
`define EMR_CTRL_MODE_LSB 11
`define EMR_CTRL_MODE_MSB 8
`define EMR_CTRL_MODE_W 4
`endif

// >>> tb/tb.sv
// self-checking bench for the rx pattern mask / max frame length registers
// assumes emr_top acks each wishbone request one cycle after taking it
`include "emr_regs.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [63:0] rx_pattern_mask_o;
    logic [15:0] max_frame_octets_o;
    logic receive_enable_bit_o;
    logic [3:0] pattern_match_mode_field_o;
    logic mask_lock_err_o;
    int fail_count = 0;
    int checked = 0;
    logic [31:0] q;

    emr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_pattern_mask_o(rx_pattern_mask_o),
        .max_frame_octets_o(max_frame_octets_o), .receive_enable_bit_o(receive_enable_bit_o),
        .pattern_match_mode_field_o(pattern_match_mode_field_o),
        .mask_lock_err_o(mask_lock_err_o));

    always #12.5 clk_i = ~clk_i;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one classic cycle; the request is held until ack is sampled high
    task automatic wb(input logic we, input logic [5:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task automatic t_reset;
        wb(1'b0, `EMR_OFF_MAXLEN, 4'hF, 32'h0);
        chk(q, 32'h000005EE);
        chk(max_frame_octets_o, 16'h05EE);
        chk(rx_pattern_mask_o, 64'h0);
    endtask : t_reset

    task automatic t_mask;
        wb(1'b1, `EMR_OFF_MASK_LO, 4'hF, 32'h33221100);
        wb(1'b1, `EMR_OFF_MASK_HI, 4'hF, 32'h77665544);
        chk(rx_pattern_mask_o, 64'h7766554433221100);
        wb(1'b0, `EMR_OFF_MASK_HI, 4'hF, 32'h0);
        chk(q, 32'h77665544);
    endtask : t_mask

    // set, clear and invert touch only the bits written as one
    task automatic t_alias;
        wb(1'b1, `EMR_OFF_MASK_LO | 6'h04, 4'hF, 32'h0000F00F);
        chk(rx_pattern_mask_o[31:0], 32'h3322F10F);
        wb(1'b1, `EMR_OFF_MASK_LO | 6'h08, 4'hF, 32'h00000101);
        chk(rx_pattern_mask_o[31:0], 32'h3322F00E);
        wb(1'b1, `EMR_OFF_MASK_LO | 6'h0C, 4'hF, 32'hFF0000FF);
        chk(rx_pattern_mask_o, 64'h77665544CC22F0F1);
    endtask : t_alias

    task automatic t_width;
        wb(1'b1, `EMR_OFF_MASK_LO, 4'h1, 32'hFFFFFFFF);
        chk(rx_pattern_mask_o[31:0], 32'hCC22F0F1);
        wb(1'b1, `EMR_OFF_MASK_LO, 4'hC, 32'h1234ABCD);
        chk(rx_pattern_mask_o[31:0], 32'h1234F0F1);
        wb(1'b1, `EMR_OFF_MAXLEN, 4'h3, 32'h000005F2);
        wb(1'b0, `EMR_OFF_MAXLEN, 4'hF, 32'h0);
        chk(q, 32'h000005F2);
        wb(1'b1, `EMR_OFF_MAXLEN, 4'hF, 32'hFFFF05F7);
        wb(1'b1, `EMR_OFF_MAXLEN, 4'h2, 32'h0000FF00);
        wb(1'b0, `EMR_OFF_MAXLEN, 4'hF, 32'h0);
        chk(q, 32'h000005F7);
        chk(max_frame_octets_o, 16'h05F7);
    endtask : t_width

    // a deliberate breach: the mask write lands, the sticky flag records it
    task automatic t_lock;
        wb(1'b1, `EMR_OFF_CTRL, 4'hF, 32'h00000300);
        chk({receive_enable_bit_o, pattern_match_mode_field_o}, 5'h13);
        wb(1'b1, `EMR_OFF_MASK_LO, 4'hF, 32'h0000FFFF);
        chk({mask_lock_err_o, rx_pattern_mask_o[31:0]}, 33'h10000FFFF);
        wb(1'b0, `EMR_OFF_CTRL, 4'hF, 32'h0);
        chk(q, 32'h00010300);
        wb(1'b1, `EMR_OFF_CTRL, 4'hF, 32'h00010000);
        chk({mask_lock_err_o, receive_enable_bit_o, pattern_match_mode_field_o}, 6'h00);
    endtask : t_lock

    // a second reset in mid-run brings every register back
    task automatic t_rerst;
        wb(1'b1, `EMR_OFF_MAXLEN, 4'hF, 32'h00000400);
        chk(max_frame_octets_o, 16'h0400);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(max_frame_octets_o, 16'h05EE);
        chk(rx_pattern_mask_o, 64'h0);
        wb(1'b0, `EMR_OFF_MAXLEN, 4'hF, 32'h0);
        chk(q, 32'h000005EE);
    endtask : t_rerst

    task automatic summarize;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_mask();
        t_alias();
        t_width();
        t_lock();
        t_rerst();
        summarize();
    end

    // about 65 cycles of traffic; a hang beyond 2000 ends the run
    initial begin
        repeat (2000) @(posedge clk_i);
        fail_count++;
        summarize();
    end
endmodule : tb
